// [verilog/fupc_ctrl.v]
`timescale 1ns/1ns
`default_nettype none
`include "fupc_consts.vh"
// Contract
// - Array pages are 512 bytes; erase affects one whole page.
// - Eight sectors, each separately protectable.
// - Sector index comes from upper address bits, size per configuration.
// - Page select bit 7 overlays information area on FE00h-FFFFh.
// - Overlay affects program-memory loads only, never instruction fetches.
// - Information area is read-only.
// - FE40h-FE53h hold a zero-padded 20-character identifier.
// - High and low bytes form the 16-bit clock kHz value.
// - Read protect blocks debug and bypass readout.
// - Reset enters the locked state.
// - Out-of-sequence command or page write locks the controller; a repeated page write in step 1 instead stays in step 1 with the new page.
// - Unlock is 00h, page, 73h, 8Ch, same page.
// - Protected sectors refuse program and erase.
// - Sector protect register clears on reset.
// - Software writes can only set protect bits.
// - Command 5Eh maps protect register at the page address.
// - Any other command restores page select access.
// - Shared address is FF9h; protect set by 00h, 5Eh, access, 00h.
// - Write protect option blocks all program and erase.
// - Controller makes array control signals and timing.
// - Programming only inside unlocked page; other writes ignored.
// - Programming only clears bits; erase sets them.
// - Command 95h erases the page, then relocks.
// - Write-only command shares address with read-only status.
module fupc_ctrl
(
   input  wire        ref_clk,         // System clock, 100 MHz.
   input  wire        rst,             // Asynchronous reset, active high.
   input  wire        reg_wr,          // Register-file write strobe.
   input  wire        reg_rd,          // Register-file read strobe.
   input  wire [11:0] reg_addr,        // Register-file address.
   input  wire [7:0]  reg_wdata,       // Register write data.
   output reg  [7:0]  reg_rdata_reg,   // Register read data.
   input  wire        mem_wr,          // User memory write.
   input  wire        mem_rd,          // Program-memory load read.
   input  wire        fetch,           // Instruction fetch read.
   input  wire [15:0] mem_addr,        // Memory address.
   input  wire [7:0]  mem_wdata,       // Memory write data.
   output reg  [7:0]  mem_rdata_reg,   // Memory read data.
   input  wire [7:0]  array_rdata,     // Data from the flash array.
   input  wire [1:0]  sector_shift,    // Sector size: 0=2K, 1=4K, 2=8K.
   input  wire        opt_write_prot,  // Write protect option bit.
   input  wire        opt_read_prot,   // Read protect option bit.
   input  wire        debug_rd,        // Debugger or bypass read request.
   output reg         debug_block_reg, // Debugger or bypass read refused.
   output reg         cpu_stall_reg,   // CPU idles during an operation.
   output reg  [15:0] array_addr_reg,  // Flash array address.
   output reg  [7:0]  array_wdata_reg, // Flash array program data.
   output reg         array_prog_reg,  // Array program pulse.
   output reg         array_erase_reg, // Array page erase pulse.
   output reg         array_rd_reg,    // Array read strobe.
   output reg         info_sel_reg     // Read data comes from the information area.
);
   // One-hot controller states.
   localparam [6:0] S_LOCKED = 7'h01;
   localparam [6:0] S_STEP1  = 7'h02;
   localparam [6:0] S_STEP2  = 7'h04;
   localparam [6:0] S_STEP3  = 7'h08;
   localparam [6:0] S_OPEN   = 7'h10;
   localparam [6:0] S_PROG   = 7'h20;
   localparam [6:0] S_ERASE  = 7'h40;

   // Reset value of the kHz timing word, loaded into its two bytes below.
   localparam [15:0] FREQ_RESET = `FUPC_FREQ_RESET;

   reg  [6:0]  state_reg;
   reg  [6:0]  state_next;
   reg         prot_sel_reg;
   reg  [7:0]  page_reg;
   reg  [7:0]  prot_reg;
   reg  [7:0]  freq_hi_reg;
   reg  [7:0]  freq_lo_reg;
   reg  [7:0]  ram_old_reg;
   reg         timer_start;
   reg  [15:0] timer_us;
   wire        timer_busy;
   wire [15:0] clock_khz_value;
   wire [7:0]  info_data;
   wire        wr_cmd;
   wire        wr_page;
   wire        in_info;

   // Sector of an address, from its upper bits.
   function [2:0] sector_of;
      input [15:0] a;
      input [1:0]  sh;
      begin
         case (sh)
            2'd0:    sector_of = a[13:11];
            2'd1:    sector_of = a[14:12];
            default: sector_of = a[15:13];
         endcase
      end
   endfunction

   // Whether the open page may be altered.
   function allowed;
      input [6:0]  pg;
      input [7:0]  prot;
      input [1:0]  sh;
      input        wp;
      begin
         allowed = !wp && !prot[sector_of({pg, 9'h000}, sh)];
      end
   endfunction

   // Timing word, register-file write decodes and the overlay window.
   assign clock_khz_value = {freq_hi_reg, freq_lo_reg};
   assign wr_cmd  = reg_wr && (reg_addr == `FUPC_ADDR_CMD);
   assign wr_page = reg_wr && (reg_addr == `FUPC_ADDR_PAGE);
   assign in_info = page_reg[`FUPC_INFO_EN_BIT] && (mem_addr >= `FUPC_INFO_BASE);

   // One timer serves program and erase, since only one operation runs at a time.
   fupc_pulse_timer u_timer
   (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .start    (timer_start),
      .usec     (timer_us),
      .khz      (clock_khz_value),
      .busy_reg (timer_busy)
   );

   // The information area has no write port, so user code can never alter it.
   fupc_info_rom u_info
   (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .offset   (mem_addr[8:0]),
      .data_reg (info_data)
   );

   // Unlock sequencer and operation control.
   always @*
   begin
      state_next  = state_reg;
      timer_start = 1'b0;
      timer_us    = `FUPC_PROG_US;
      case (state_reg)
         // A page write starts the sequence unless it lands in the protect register.
         S_LOCKED:
            if (wr_page && !prot_sel_reg)
               state_next = S_STEP1;
         S_STEP1:
            if (wr_cmd)
               state_next = (reg_wdata == `FUPC_CMD_UNLOCK1) ? S_STEP2 : S_LOCKED;
            else if (wr_page && !prot_sel_reg)
               state_next = S_STEP1;
         S_STEP2:
            if (wr_cmd)
               state_next = (reg_wdata == `FUPC_CMD_UNLOCK2) ? S_STEP3 : S_LOCKED;
            else if (wr_page)
               state_next = S_LOCKED;
         S_STEP3:
            if (wr_cmd)
               state_next = S_LOCKED;
            else if (wr_page)
               state_next = (reg_wdata == page_reg) ? S_OPEN : S_LOCKED;
         // Only the open page may change; any other command or page write closes it.
         S_OPEN:
            if (wr_cmd && reg_wdata == `FUPC_CMD_PAGE_ERASE)
            begin
               if (allowed(page_reg[6:0], prot_reg, sector_shift, opt_write_prot))
               begin
                  state_next  = S_ERASE;
                  timer_start = 1'b1;
                  timer_us    = `FUPC_ERASE_US;
               end
               else
                  state_next = S_LOCKED;
            end
            else if (wr_cmd || wr_page)
               state_next = S_LOCKED;
            else if (mem_wr && mem_addr[15:9] == page_reg[6:0]
                     && allowed(page_reg[6:0], prot_reg, sector_shift, opt_write_prot))
            begin
               state_next  = S_PROG;
               timer_start = 1'b1;
            end
         // The CPU stays stalled until the program pulse has ended.
         S_PROG:
            if (!timer_busy && !timer_start && !cpu_stall_reg)
               state_next = S_OPEN;
            else if (!timer_busy && cpu_stall_reg)
               state_next = S_OPEN;
         // An erase always relocks, so every erase needs a fresh unlock.
         S_ERASE:
            if (!timer_busy && cpu_stall_reg)
               state_next = S_LOCKED;
         default:
            state_next = S_LOCKED;
      endcase
   end

   // State, page, protect and frequency registers.
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg    <= S_LOCKED;
         prot_sel_reg <= 1'b0;
         page_reg     <= 8'h00;
         prot_reg     <= `FUPC_PROT_RESET;
         freq_hi_reg  <= FREQ_RESET[15:8];
         freq_lo_reg  <= FREQ_RESET[7:0];
      end
      else
      begin
         state_reg <= state_next;
         if (wr_cmd)
            prot_sel_reg <= (reg_wdata == `FUPC_CMD_PROT_SEL);
         if (wr_page && prot_sel_reg)
            prot_reg <= prot_reg | reg_wdata;
         else if (wr_page && (state_reg == S_LOCKED || state_reg == S_STEP1))
            page_reg <= reg_wdata;
         if (reg_wr && reg_addr == `FUPC_ADDR_FREQ_HI)
            freq_hi_reg <= reg_wdata;
         if (reg_wr && reg_addr == `FUPC_ADDR_FREQ_LO)
            freq_lo_reg <= reg_wdata;
      end
   end

   // Array control signals and timing.
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cpu_stall_reg   <= 1'b0;
         array_addr_reg  <= 16'h0000;
         array_wdata_reg <= 8'hff;
         array_prog_reg  <= 1'b0;
         array_erase_reg <= 1'b0;
         array_rd_reg    <= 1'b0;
         ram_old_reg     <= 8'hff;
      end
      else
      begin
         cpu_stall_reg   <= (state_next == S_PROG) || (state_next == S_ERASE);
         array_prog_reg  <= (state_reg == S_PROG) && timer_busy;
         array_erase_reg <= (state_reg == S_ERASE) && timer_busy;
         array_rd_reg    <= mem_rd || fetch || (timer_start && state_reg == S_OPEN && mem_wr);
         // A program start latches the target address and the new data.
         if (timer_start && state_reg == S_OPEN && mem_wr)
         begin
            array_addr_reg <= mem_addr;
            ram_old_reg    <= mem_wdata;
         end
         else if (timer_start)
            array_addr_reg <= {page_reg[6:0], 9'h000};
         else if (mem_rd || fetch)
            array_addr_reg <= mem_addr;
         if (state_reg == S_PROG)
            array_wdata_reg <= array_rdata & ram_old_reg;
      end
   end

   // Read paths: status, registers, memory and debug refusal.
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         reg_rdata_reg   <= 8'h00;
         mem_rdata_reg   <= 8'h00;
         info_sel_reg    <= 1'b0;
         debug_block_reg <= 1'b0;
      end
      else
      begin
         info_sel_reg    <= mem_rd && !fetch && in_info;
         mem_rdata_reg   <= info_sel_reg ? info_data : array_rdata;
         debug_block_reg <= debug_rd && opt_read_prot;
         if (reg_rd)
         begin
            case (reg_addr)
               // Status shares the command address; commands are never read back.
               `FUPC_ADDR_CMD:
                  case (state_reg)
                     S_STEP1: reg_rdata_reg <= {2'b00, `FUPC_ST_STEP1};
                     S_STEP2: reg_rdata_reg <= {2'b00, `FUPC_ST_STEP2};
                     S_STEP3: reg_rdata_reg <= {2'b00, `FUPC_ST_STEP3};
                     S_OPEN:  reg_rdata_reg <= {2'b00, `FUPC_ST_UNLOCKED};
                     S_PROG:  reg_rdata_reg <= {2'b00, `FUPC_ST_PROGRAM};
                     S_ERASE: reg_rdata_reg <= {2'b00, `FUPC_ST_ERASE};
                     default: reg_rdata_reg <= {2'b00, prot_sel_reg ? `FUPC_ST_PROT_SEL : `FUPC_ST_LOCKED};
                  endcase
               `FUPC_ADDR_PAGE:    reg_rdata_reg <= prot_sel_reg ? prot_reg : page_reg;
               `FUPC_ADDR_FREQ_HI: reg_rdata_reg <= freq_hi_reg;
               `FUPC_ADDR_FREQ_LO: reg_rdata_reg <= freq_lo_reg;
               default:            reg_rdata_reg <= 8'h00;
            endcase
         end
      end
   end
endmodule // fupc_ctrl
`default_nettype wire

// [inc/fupc_consts.vh]
`ifndef FUPC_CONSTS_VH
`define FUPC_CONSTS_VH
// Register-file addresses.
`define FUPC_ADDR_CMD        12'hff8
`define FUPC_ADDR_PAGE       12'hff9
`define FUPC_ADDR_FREQ_HI    12'hffa
`define FUPC_ADDR_FREQ_LO    12'hffb
// Command codes.
`define FUPC_CMD_RESET       8'h00
`define FUPC_CMD_UNLOCK1     8'h73
`define FUPC_CMD_UNLOCK2     8'h8c
`define FUPC_CMD_PAGE_ERASE  8'h95
`define FUPC_CMD_PROT_SEL    8'h5e
// Array organisation.
`define FUPC_PAGE_BYTES      512
`define FUPC_NUM_SECTORS     8
`define FUPC_INFO_EN_BIT     7
`define FUPC_INFO_BASE       16'hfe00
`define FUPC_PARTID_FIRST    9'h040
`define FUPC_PARTID_LAST     9'h053
// Reset values.
`define FUPC_PROT_RESET      8'h00
`define FUPC_FREQ_RESET      16'h0000
// Status codes.
`define FUPC_ST_LOCKED       6'h00
`define FUPC_ST_STEP1        6'h01
`define FUPC_ST_STEP2        6'h02
`define FUPC_ST_STEP3        6'h03
`define FUPC_ST_UNLOCKED     6'h04
`define FUPC_ST_PROT_SEL     6'h05
`define FUPC_ST_PROGRAM      6'h08
`define FUPC_ST_ERASE        6'h09
// Pulse durations in microseconds.
`define FUPC_PROG_US         16'h0028
`define FUPC_ERASE_US        16'h2710
`endif

// [verilog/fupc_pulse_timer.v]
`timescale 1ns/1ns
`default_nettype none
// Counts a pulse of a given number of microseconds, scaled by the clock in kHz.
module fupc_pulse_timer
(
   input  wire        ref_clk,    // System clock.
   input  wire        rst,        // Asynchronous reset.
   input  wire        start,      // Begin a pulse.
   input  wire [15:0] usec,       // Pulse length in microseconds.
   input  wire [15:0] khz,        // Clock frequency in kHz.
   output reg         busy_reg    // High while the pulse runs.
);
   reg  [31:0] count_reg;
   wire [31:0] cycles;

   // Cycles = usec * kHz / 1000, at least one.
   assign cycles = ({16'h0000, usec} * {16'h0000, khz}) / 32'h0000_03e8;

   // Counts down the derived number of cycles.
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         count_reg <= 32'h0000_0000;
         busy_reg  <= 1'b0;
      end
      else if (start && !busy_reg)
      begin
         count_reg <= (cycles == 32'h0000_0000) ? 32'h0000_0001 : cycles;
         busy_reg  <= 1'b1;
      end
      else if (busy_reg)
      begin
         count_reg <= count_reg - 32'h0000_0001;
         busy_reg  <= (count_reg != 32'h0000_0001);
      end
   end
endmodule // fupc_pulse_timer
`default_nettype wire

// [verilog/fupc_info_rom.v]
`timescale 1ns/1ns
`default_nettype none
`include "fupc_consts.vh"
// Read-only information area; only the part identifier bytes are non-zero.
module fupc_info_rom
(
   input  wire       ref_clk,     // System clock.
   input  wire       rst,         // Asynchronous reset.
   input  wire [8:0] offset,      // Byte offset in the area.
   output reg  [7:0] data_reg     // Registered read data.
);
   parameter [159:0] PART_ID = {"ARBITRARY-PART-0001", 8'h00}; // Arbitrary identifier.

   wire [4:0] idx;
   assign idx = offset[4:0] + 5'h0c;

   // Returns the identifier byte, zero elsewhere; the area has no write path.
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         data_reg <= 8'h00;
      else if (offset >= `FUPC_PARTID_FIRST && offset <= `FUPC_PARTID_LAST)
         data_reg <= PART_ID[8'd159 - {idx - 5'h0c, 3'b000} -: 8];
      else
         data_reg <= 8'h00;
   end
endmodule // fupc_info_rom
`default_nettype wire

// [testbench/fupc_checker.sv]
`timescale 1ns/1ns
`default_nettype none
// Watches the controller ports for protection and pulse relations.
module fupc_checker
(
   input wire logic        ref_clk,         // System clock.
   input wire logic        rst,             // Asynchronous reset.
   input wire logic        reg_wr,          // Register write strobe.
   input wire logic        reg_rd,          // Register read strobe.
   input wire logic [11:0] reg_addr,        // Register address.
   input wire logic [7:0]  reg_wdata,       // Register write data.
   input wire logic [7:0]  reg_rdata_reg,   // Register read data.
   input wire logic        mem_wr,          // Memory write.
   input wire logic        opt_write_prot,  // Write protect option.
   input wire logic        opt_read_prot,   // Read protect option.
   input wire logic        debug_rd,        // Debug read request.
   input wire logic        debug_block_reg, // Debug read refused.
   input wire logic        cpu_stall_reg,   // CPU stall.
   input wire logic        array_prog_reg,  // Program pulse.
   input wire logic        array_erase_reg  // Erase pulse.
);
   logic [2:0] wr_age_reg;
   logic [2:0] er_age_reg;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Ages since the last memory write and erase command, saturating at seven.
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_age_reg <= 3'h7;
         er_age_reg <= 3'h7;
      end
      else
      begin
         wr_age_reg <= mem_wr ? 3'h0 : wr_age_reg + {2'h0, wr_age_reg != 3'h7};
         er_age_reg <= (reg_wr && reg_addr == 12'hff8 && reg_wdata == 8'h95) ? 3'h0
                       : er_age_reg + {2'h0, er_age_reg != 3'h7};
      end
   end
   a_debug_blocked: assert property (debug_rd && opt_read_prot |=> debug_block_reg)
      else $error("debug read not refused");
   a_debug_allowed: assert property (!(debug_rd && opt_read_prot) |=> !debug_block_reg)
      else $error("debug read refused without cause");
   a_wp_no_prog: assert property ($rose(array_prog_reg) |-> !opt_write_prot)
      else $error("program under write protect");
   a_wp_no_erase: assert property ($rose(array_erase_reg) |-> !opt_write_prot)
      else $error("erase under write protect");
   a_prog_stalls: assert property (array_prog_reg |-> cpu_stall_reg)
      else $error("program pulse without stall");
   a_erase_stalls: assert property (array_erase_reg |-> cpu_stall_reg)
      else $error("erase pulse without stall");
   a_prog_cause: assert property ($rose(array_prog_reg) |-> wr_age_reg < 3'h5)
      else $error("program pulse without memory write");
   a_erase_cause: assert property ($rose(array_erase_reg) |-> er_age_reg < 3'h5)
      else $error("erase pulse without erase command");
   a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata_reg))
      else $error("read data changed without read");
endmodule // fupc_checker
bind fupc_ctrl fupc_checker u_chk (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_reg(reg_rdata_reg), .mem_wr(mem_wr),
   .opt_write_prot(opt_write_prot), .opt_read_prot(opt_read_prot), .debug_rd(debug_rd),
   .debug_block_reg(debug_block_reg), .cpu_stall_reg(cpu_stall_reg),
   .array_prog_reg(array_prog_reg), .array_erase_reg(array_erase_reg));
`default_nettype wire

// [testbench/fupc_flash_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Behavioural flash array behind the controller.
module fupc_flash_model
(
   input  wire logic        ref_clk,     // System clock.
   input  wire logic [15:0] array_addr,  // Array address.
   input  wire logic [7:0]  array_wdata, // Program data.
   input  wire logic        array_prog,  // Program pulse.
   input  wire logic        array_erase, // Page erase pulse.
   output logic [7:0]       array_rdata  // Read data.
);
   logic [7:0] mem [0:65535];
   logic       prog_q = 1'b0;
   logic       erase_q = 1'b0;
   // A blank array reads all ones.
   initial
   begin
      for (int i = 0; i < 65536; i++)
         mem[i] = 8'hff;
   end
   // The array cells read asynchronously from the address lines.
   assign array_rdata = mem[array_addr];
   // Programming can only clear bits; erase sets one whole page to ones.
   always @(posedge ref_clk)
   begin
      prog_q <= array_prog;
      erase_q <= array_erase;
      if (array_prog && !prog_q)
         mem[array_addr] <= mem[array_addr] & array_wdata;
      if (array_erase && !erase_q)
         for (int i = 0; i < 512; i++)
            mem[{array_addr[15:9], i[8:0]}] <= 8'hff;
   end
endmodule // fupc_flash_model
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "fupc_consts.vh"
// Drives the controller through register and memory accesses.
module tb_top;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, mem_wr = 1'b0, mem_rd = 1'b0, fetch = 1'b0;
   logic        wp = 1'b0, rp = 1'b0, debug_rd = 1'b0;
   logic [1:0]  ssh = 2'h0, rs;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0]  reg_wdata = 8'h00, mem_wdata = 8'h00, d;
   logic [15:0] mem_addr = 16'h0000;
   wire logic [7:0]  reg_rdata_reg, mem_rdata_reg, array_rdata, array_wdata_reg;
   wire logic [15:0] array_addr_reg;
   wire logic        debug_block_reg, cpu_stall_reg, array_prog_reg, array_erase_reg;
   wire logic        array_rd_reg, info_sel_reg;
   int          n_mismatch = 0, n_compared = 0, cycles = 0;

   fupc_ctrl uut (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_reg(reg_rdata_reg), .mem_wr(mem_wr), .mem_rd(mem_rd),
      .fetch(fetch), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata_reg(mem_rdata_reg),
      .array_rdata(array_rdata), .sector_shift(ssh), .opt_write_prot(wp), .opt_read_prot(rp),
      .debug_rd(debug_rd), .debug_block_reg(debug_block_reg), .cpu_stall_reg(cpu_stall_reg),
      .array_addr_reg(array_addr_reg), .array_wdata_reg(array_wdata_reg),
      .array_prog_reg(array_prog_reg), .array_erase_reg(array_erase_reg), .array_rd_reg(array_rd_reg),
      .info_sel_reg(info_sel_reg));
   fupc_flash_model u_flash (.ref_clk(ref_clk), .array_addr(array_addr_reg), .array_wdata(array_wdata_reg),
      .array_prog(array_prog_reg), .array_erase(array_erase_reg), .array_rdata(array_rdata));

   // Clock and a hang limit well above the expected run length.
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         give_verdict;
      end
   end

   task give_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Moves to just after the next rising edge.
   task tick;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      tick;
      reg_wr = 1'b0;
      tick;
   endtask
   task automatic rd(input logic [11:0] a);
      reg_rd = 1'b1;
      reg_addr = a;
      tick;
      reg_rd = 1'b0;
      d = reg_rdata_reg;
      tick;
   endtask
   task automatic mread(input logic [15:0] a, input logic f);
      mem_rd = !f;
      fetch = f;
      mem_addr = a;
      tick;
      rs = {array_rd_reg, info_sel_reg};
      mem_rd = 1'b0;
      fetch = 1'b0;
      tick;
      d = mem_rdata_reg;
      tick;
   endtask
   // Writes memory, then waits a bounded time for any stall to start and end.
   task automatic mwrite(input logic [15:0] a, input logic [7:0] v);
      mem_wr = 1'b1;
      mem_addr = a;
      mem_wdata = v;
      tick;
      mem_wr = 1'b0;
      for (int i = 0; i < 8 && cpu_stall_reg !== 1'b1; i++)
         tick;
      for (int i = 0; i < 2000 && cpu_stall_reg !== 1'b0; i++)
         tick;
   endtask
   task automatic unlock(input logic [7:0] p);
      wr(`FUPC_ADDR_CMD, 8'h00);
      wr(`FUPC_ADDR_PAGE, p);
      wr(`FUPC_ADDR_CMD, 8'h73);
      wr(`FUPC_ADDR_CMD, 8'h8c);
      wr(`FUPC_ADDR_PAGE, p);
   endtask

   // Main sequence; 25 kHz keeps program at one cycle and erase at 250 cycles.
   initial
   begin
      repeat (20) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      tick;
      rd(`FUPC_ADDR_CMD); chk8("status", 8'h00, d);
      wr(`FUPC_ADDR_CMD, 8'h00);
      wr(`FUPC_ADDR_CMD, 8'h5e);
      rd(`FUPC_ADDR_PAGE); chk8("protect", 8'h00, d);
      wr(`FUPC_ADDR_FREQ_HI, 8'h00);
      wr(`FUPC_ADDR_FREQ_LO, 8'h19);
      wr(`FUPC_ADDR_CMD, 8'h00);
      wr(`FUPC_ADDR_PAGE, 8'h08);
      wr(`FUPC_ADDR_CMD, 8'h73);
      wr(`FUPC_ADDR_CMD, 8'h00);
      rd(`FUPC_ADDR_CMD); chk8("status", 8'h00, d);
      unlock(8'h08);
      wr(`FUPC_ADDR_PAGE, 8'h09);
      rd(`FUPC_ADDR_CMD); chk8("status", 8'h00, d);
      unlock(8'h08);
      rd(`FUPC_ADDR_CMD); chk8("status", 8'h04, d);
      mwrite(16'h1004, 8'h5a); chk8("cell", 8'h5a, u_flash.mem[16'h1004]);
      mwrite(16'h1004, 8'h0f); chk8("cell", 8'h0a, u_flash.mem[16'h1004]);
      mwrite(16'h1204, 8'h00); chk8("cell", 8'hff, u_flash.mem[16'h1204]);
      wr(`FUPC_ADDR_CMD, 8'h95); chk8("stall", 8'h01, {7'h00, cpu_stall_reg});
      mwrite(16'h0000, 8'hff);
      chk8("cell", 8'hff, u_flash.mem[16'h1004]);
      rd(`FUPC_ADDR_CMD); chk8("status", 8'h00, d);
      wr(`FUPC_ADDR_CMD, 8'h5e);
      wr(`FUPC_ADDR_PAGE, 8'h01);
      wr(`FUPC_ADDR_PAGE, 8'h00);
      rd(`FUPC_ADDR_PAGE); chk8("protect", 8'h01, d);
      unlock(8'h00);
      mwrite(16'h0010, 8'h00); chk8("cell", 8'hff, u_flash.mem[16'h0010]);
      ssh = 2'h2;
      unlock(8'h08);
      mwrite(16'h100c, 8'h00); chk8("cell", 8'hff, u_flash.mem[16'h100c]);
      ssh = 2'h0;
      unlock(8'h08);
      mwrite(16'h100c, 8'h00); chk8("cell", 8'h00, u_flash.mem[16'h100c]);
      wp = 1'b1;
      unlock(8'h08);
      mwrite(16'h1008, 8'h00); chk8("cell", 8'hff, u_flash.mem[16'h1008]);
      wp = 1'b0;
      wr(`FUPC_ADDR_CMD, 8'h00);
      wr(`FUPC_ADDR_PAGE, 8'h80);
      mread(16'hfe40, 1'b0); chk8("load", 8'h41, d);
      chk8("read_flags", 8'h03, {6'h00, rs});
      mread(16'hfe53, 1'b0); chk8("load", 8'h00, d);
      mread(16'hfe40, 1'b1); chk8("fetch", 8'hff, d);
      chk8("read_flags", 8'h02, {6'h00, rs});
      wr(`FUPC_ADDR_PAGE, 8'h00);
      rp = 1'b1;
      debug_rd = 1'b1;
      tick;
      debug_rd = 1'b0;
      chk8("debug_block", 8'h01, {7'h00, debug_block_reg});
      rp = 1'b0;
      tick;
      rst = 1'b1;
      tick;
      rst = 1'b0;
      tick;
      wr(`FUPC_ADDR_CMD, 8'h5e);
      rd(`FUPC_ADDR_PAGE); chk8("protect", 8'h00, d);
      give_verdict;
   end
endmodule // tb_top
`default_nettype wire
